// [rtl/cfs_map.vh]
// Register offsets, fields and fault codes of the cutter fault supervisor
`ifndef CFS_MAP_VH
`define CFS_MAP_VH

// Register byte offsets
`define CFS_REG_CTRL 12'h000
`define CFS_REG_STATUS 12'h004
`define CFS_REG_CODE 12'h008
`define CFS_REG_IRQ_STAT 12'h00c
`define CFS_REG_IRQ_MASK 12'h010
`define CFS_REG_WDOG 12'h014

// Control register fields
`define CFS_CTRL_ENABLE 0
`define CFS_CTRL_CLEAR 1
`define CFS_CTRL_KICK 2

// Status register fields
`define CFS_ST_ERROR 0
`define CFS_ST_HOLD 1
`define CFS_ST_HWERR 2
`define CFS_ST_CUTTING 3
`define CFS_ST_REFUSE 4

// Interrupt bits
`define CFS_IRQ_FAULT 0
`define CFS_IRQ_REPORT 1
`define CFS_IRQ_CLEARED 2
`define CFS_IRQ_W 3

// Fault codes
`define CFS_CODE_HW 8'h00
`define CFS_CODE_PWR_LOW 8'h01
`define CFS_CODE_NO_CUT 8'h02
`define CFS_CODE_NO_HOME 8'h03
`define CFS_CODE_MARK_OVF 8'h04
`define CFS_CODE_PROF_OVF 8'h05
`define CFS_CODE_SHORT 8'h06
`define CFS_CODE_FW 8'h07
`define CFS_CODE_WDOG 8'h09
`define CFS_CODE_SUPPLY0 8'h0a
`define CFS_CODE_TEMP 8'h0f
`define CFS_CODE_BUS 8'h10
`define CFS_CODE_NONE 8'hff

// Reset values
`define CFS_RST_CTRL 3'h0
`define CFS_RST_MASK 3'h0
`define CFS_RST_WDOG 16'h0000

// Timing: watchdog tick in us, converted at 100 MHz
`define CFS_CLK_MHZ 100
`define CFS_WDOG_TICK_US 10
`define CFS_WDOG_TICK_CYC (`CFS_WDOG_TICK_US * `CFS_CLK_MHZ)

`endif

// [rtl/cfs_fault_supervisor.v]
// Cutter fault supervisor: fault detection, code latch, hold and APB regs
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_map.vh"

// Overview of operation
// - On a stopping fault, finish the cut in progress, then hold the roll.
// - The error output is high whenever an error state is active.
// - Clear command or dropped enable clears the error, except special codes.
// - A cause still present after clearing re-enters the error at once.
// - Failed self-check gives code 00, reports only, cleared by power cycle.
// - Low supply gives code 01, removed by itself when the supply recovers.
// - Missing cut pulse in homing or in the sync zone gives code 02.
// - Cycle start away from home gives code 03, reported only.
// - Print-mark buffer overflow gives code 04.
// - Profile pre-calculation overflow gives code 05.
// - Cut length too short at cycle start gives code 06 and the cut is refused.
// - Unexpected control sequencing state gives a firmware-fault code.
// - Processing cycle exceeding its time gives watchdog code 09.
// - An internal rail monitor out of range gives a supply-fault code.
// - Overtemperature gives code 15.
// - Fieldbus module failure gives a dedicated fault code.
module cfs_fault_supervisor #(
    parameter NUM_RAILS = 5,
    parameter WDOG_W = 16
) (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Machine control pins
    input wire ctrl_enable_pin,
    input wire clear_fault_pin,
    // Fault sources (asynchronous pins)
    input wire selftest_fail,
    input wire supply_low,
    input wire homing_active,
    input wire sync_zone,
    input wire cut_pulse,
    input wire rev_mark,
    input wire cycle_start,
    input wire at_home,
    input wire mark_buf_ovf,
    input wire profile_ovf,
    input wire cut_len_short,
    input wire seq_bad_state,
    input wire proc_cycle_tick,
    input wire [NUM_RAILS-1:0] rail_fault,
    input wire over_temp,
    input wire fieldbus_fail,
    input wire cut_active,
    // Outputs
    output reg error_out,
    output reg roll_hold,
    output reg cut_refuse,
    output wire irq
);

    localparam NSYNC = 16 + NUM_RAILS;
    localparam ST_RUN = 2'd0;
    localparam ST_FINISH = 2'd1;
    localparam ST_HOLD = 2'd2;

    // Two-flop synchronisers for all pins
    reg [NSYNC+1:0] meta_q;
    reg [NSYNC+1:0] sync_q;
    wire [NSYNC+1:0] raw_all = {rail_fault, ctrl_enable_pin,
        clear_fault_pin, selftest_fail, supply_low, homing_active,
        sync_zone, cut_pulse, rev_mark, cycle_start, at_home, mark_buf_ovf,
        profile_ovf, cut_len_short, seq_bad_state, proc_cycle_tick,
        over_temp, fieldbus_fail, cut_active};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= {(NSYNC+2){1'b0}};
            sync_q <= {(NSYNC+2){1'b0}};
        end else begin
            meta_q <= raw_all;
            sync_q <= meta_q;
        end
    end

    wire s_cut_active = sync_q[0];
    wire s_bus_fail = sync_q[1];
    wire s_temp = sync_q[2];
    wire s_tick = sync_q[3];
    wire s_seq_bad = sync_q[4];
    wire s_short = sync_q[5];
    wire s_prof = sync_q[6];
    wire s_mark = sync_q[7];
    wire s_home = sync_q[8];
    wire s_start = sync_q[9];
    wire s_rev = sync_q[10];
    wire s_cutp = sync_q[11];
    wire s_zone = sync_q[12];
    wire s_homing = sync_q[13];
    wire s_pwr_low = sync_q[14];
    wire s_selftest = sync_q[15];
    wire s_clr_pin = sync_q[16];
    wire s_en_pin = sync_q[17];
    wire [NUM_RAILS-1:0] s_rail = sync_q[NSYNC+1:18];

    // Registers
    reg [2:0] ctrl_q;
    reg [2:0] mask_q;
    reg [2:0] istat_q;
    reg [WDOG_W-1:0] wdog_lim_q;
    reg [7:0] code_q;
    reg err_q;
    reg hw_err_q;
    reg [1:0] state_q;
    reg [WDOG_W-1:0] wd_cnt_q;
    reg [15:0] pre_q;
    reg [4:0] edge_q;
    reg cut_seen_q;
    reg rev_arm_q;
    reg [NUM_RAILS-1:0] rail_seen_q;

    wire wr = psel && penable && pwrite;
    wire rd_ok = (paddr == `CFS_REG_CTRL) || (paddr == `CFS_REG_STATUS) ||
        (paddr == `CFS_REG_CODE) || (paddr == `CFS_REG_IRQ_STAT) ||
        (paddr == `CFS_REG_IRQ_MASK) || (paddr == `CFS_REG_WDOG);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !rd_ok;

    // Edge detection on second-stage signals only
    wire start_rise = s_start && !edge_q[0];
    wire zone_fall = !s_zone && edge_q[1];
    wire rev_rise = s_rev && !edge_q[2];
    wire tick_rise = s_tick && !edge_q[3];
    wire cutp_rise = s_cutp && !edge_q[4];

    // Enable is the pin and the soft bit together; drop either clears
    wire enable = s_en_pin && ctrl_q[`CFS_CTRL_ENABLE];
    wire clear_cmd = s_clr_pin || (wr && paddr == `CFS_REG_CTRL &&
        pwdata[`CFS_CTRL_CLEAR]) || !enable;

    // Missing cut pulse window; homing needs one full revolution first,
    // and a pulse on the closing edge itself still counts as seen
    wire miss_cut = !cut_seen_q && !cutp_rise &&
        ((s_homing && rev_rise && rev_arm_q) ||
        (!s_homing && zone_fall));

    // Watchdog: limit counted in ticks; zero limit disables it
    wire wd_trip = (wdog_lim_q != {WDOG_W{1'b0}}) &&
        (wd_cnt_q >= wdog_lim_q);

    // Stopping fault priority: lowest code wins
    reg [7:0] new_code;
    reg new_stop;
    integer i;
    always @* begin
        new_stop = 1'b1;
        new_code = `CFS_CODE_NONE;
        if (s_bus_fail)
            new_code = `CFS_CODE_BUS;
        if (s_temp)
            new_code = `CFS_CODE_TEMP;
        for (i = NUM_RAILS - 1; i >= 0; i = i - 1) begin
            if (s_rail[i])
                new_code = `CFS_CODE_SUPPLY0 + i[7:0];
        end
        if (wd_trip)
            new_code = `CFS_CODE_WDOG;
        if (s_seq_bad || state_q == 2'd3)
            new_code = `CFS_CODE_FW;
        if (s_short && s_start)
            new_code = `CFS_CODE_SHORT;
        if (s_prof)
            new_code = `CFS_CODE_PROF_OVF;
        if (s_mark)
            new_code = `CFS_CODE_MARK_OVF;
        if (miss_cut)
            new_code = `CFS_CODE_NO_CUT;
        if (s_pwr_low)
            new_code = `CFS_CODE_PWR_LOW;
        if (new_code == `CFS_CODE_NONE)
            new_stop = 1'b0;
    end

    wire report_home = start_rise && !s_home;

    // Fault latch; a persisting cause reappears the cycle after a clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
            code_q <= `CFS_CODE_NONE;
            hw_err_q <= 1'b0;
        end else begin
            if (s_selftest)
                hw_err_q <= 1'b1;
            if (err_q && code_q == `CFS_CODE_PWR_LOW && !s_pwr_low) begin
                err_q <= 1'b0;
                code_q <= `CFS_CODE_NONE;
            end else if (err_q && code_q != `CFS_CODE_PWR_LOW && clear_cmd)
            begin
                err_q <= 1'b0;
                code_q <= `CFS_CODE_NONE;
            end else if (!err_q && new_stop) begin
                err_q <= 1'b1;
                code_q <= new_code;
            end else if (!err_q && report_home) begin
                code_q <= `CFS_CODE_NO_HOME;
            end else if (!err_q && hw_err_q &&
                code_q == `CFS_CODE_NONE) begin
                code_q <= `CFS_CODE_HW;
            end else if (!err_q && clear_cmd && !hw_err_q) begin
                code_q <= `CFS_CODE_NONE;
            end
        end
    end

    // Roll control: finish current cut, then hold
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RUN;
            roll_hold <= 1'b0;
            error_out <= 1'b0;
            cut_refuse <= 1'b0;
        end else begin
            error_out <= err_q || hw_err_q;
            cut_refuse <= s_short;
            case (state_q)
                ST_RUN: begin
                    roll_hold <= 1'b0;
                    if (err_q)
                        state_q <= s_cut_active ? ST_FINISH : ST_HOLD;
                end
                ST_FINISH: begin
                    // A clear during the cut returns to run without a hold
                    if (!err_q) begin
                        state_q <= ST_RUN;
                    end else if (!s_cut_active) begin
                        state_q <= ST_HOLD;
                        roll_hold <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    roll_hold <= 1'b1;
                    if (!err_q) begin
                        state_q <= ST_RUN;
                        roll_hold <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_HOLD;
                    roll_hold <= 1'b1;
                end
            endcase
        end
    end

    // Cut pulse window, edges, watchdog counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_q <= 5'h00;
            cut_seen_q <= 1'b0;
            rev_arm_q <= 1'b0;
            wd_cnt_q <= {WDOG_W{1'b0}};
            pre_q <= 16'h0000;
        end else begin
            edge_q <= {s_cutp, s_tick, s_rev, s_zone, s_start};
            if (cutp_rise)
                cut_seen_q <= 1'b1;
            else if (rev_rise || zone_fall || (s_zone && !edge_q[1]))
                cut_seen_q <= 1'b0;
            if (!s_homing)
                rev_arm_q <= 1'b0;
            else if (rev_rise)
                rev_arm_q <= 1'b1;
            if (tick_rise || !enable) begin
                wd_cnt_q <= {WDOG_W{1'b0}};
                pre_q <= 16'h0000;
            end else if (pre_q == `CFS_WDOG_TICK_CYC - 1) begin
                pre_q <= 16'h0000;
                if (!wd_trip)
                    wd_cnt_q <= wd_cnt_q + 1'b1;
            end else begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end

    // Interrupt sticky bits; a set wins over a write-one clear
    wire [2:0] ev = {err_q && clear_cmd, report_home || (s_selftest &&
        !hw_err_q), !err_q && new_stop};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= 3'h0;
            mask_q <= `CFS_RST_MASK;
            ctrl_q <= `CFS_RST_CTRL;
            wdog_lim_q <= `CFS_RST_WDOG;
        end else begin
            if (wr && paddr == `CFS_REG_IRQ_STAT)
                istat_q <= (istat_q & ~pwdata[2:0]) | ev;
            else
                istat_q <= istat_q | ev;
            if (wr && paddr == `CFS_REG_IRQ_MASK)
                mask_q <= pwdata[2:0];
            if (wr && paddr == `CFS_REG_CTRL)
                ctrl_q <= {1'b0, 1'b0, pwdata[`CFS_CTRL_ENABLE]};
            if (wr && paddr == `CFS_REG_WDOG)
                wdog_lim_q <= pwdata[WDOG_W-1:0];
        end
    end
    assign irq = |(istat_q & mask_q);

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `CFS_REG_CTRL: rd_mux[0] = ctrl_q[0];
            `CFS_REG_STATUS: rd_mux[4:0] = {cut_refuse, s_cut_active,
                hw_err_q, roll_hold, err_q};
            `CFS_REG_CODE: rd_mux[7:0] = code_q;
            `CFS_REG_IRQ_STAT: rd_mux[2:0] = istat_q;
            `CFS_REG_IRQ_MASK: rd_mux[2:0] = mask_q;
            `CFS_REG_WDOG: rd_mux[WDOG_W-1:0] = wdog_lim_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Captured in setup so read data stands through the access phase;
    // status bits are therefore one cycle old when read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= rd_mux;
    end

endmodule
`default_nettype wire

// [dv/cfs_fault_supervisor_checker.sv]
// Port assertions for the cutter fault supervisor
`timescale 1ns/1ps
`default_nettype none
module cfs_fault_supervisor_checker #(
    parameter NUM_RAILS = 5,
    parameter WDOG_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Fault side
    input wire logic selftest_fail,
    input wire logic cut_len_short,
    input wire logic cut_active,
    input wire logic error_out,
    input wire logic roll_hold,
    input wire logic cut_refuse
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] st_cnt_q;
    logic hw_seen_q;
    wire acc = psel && penable;
    wire bad = paddr > 12'h014 || paddr[1:0] != 2'h0;
    // Seven cycles cover the sync lag plus the latch and output stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_cnt_q <= 3'h0;
            hw_seen_q <= 1'b0;
        end else begin
            if (!selftest_fail)
                st_cnt_q <= 3'h0;
            else if (st_cnt_q != 3'h7)
                st_cnt_q <= st_cnt_q + 3'h1;
            hw_seen_q <= hw_seen_q || st_cnt_q == 3'h7;
        end
    end
    sequence short_held; cut_len_short [*5]; endsequence
    sequence short_gone; !cut_len_short [*5]; endsequence
    bus_ready_a: assert property (acc |-> pready)
        else $error("access without ready");
    bad_addr_a: assert property (acc && bad |->
        pslverr && (pwrite || !prdata))
        else $error("unmapped access not refused");
    good_addr_a: assert property (acc && !bad |-> !pslverr)
        else $error("mapped access refused");
    refuse_set_a: assert property (short_held |-> cut_refuse)
        else $error("short cut not refused");
    refuse_clr_a: assert property (short_gone |-> !cut_refuse)
        else $error("cut refused without cause");
    hw_sticky_a: assert property (hw_seen_q |-> error_out)
        else $error("self-check error lost");
    hold_late_a: assert property (
        $rose(roll_hold) |-> !$past(cut_active, 2))
        else $error("hold during cut");
    hold_err_a: assert property (
        roll_hold |-> error_out || $past(error_out))
        else $error("hold without error");
endmodule
bind cfs_fault_supervisor cfs_fault_supervisor_checker #(
    .NUM_RAILS(NUM_RAILS), .WDOG_W(WDOG_W)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .selftest_fail(selftest_fail),
    .cut_len_short(cut_len_short), .cut_active(cut_active),
    .error_out(error_out), .roll_hold(roll_hold), .cut_refuse(cut_refuse));
`default_nettype wire

// [dv/cfs_machine_ctrl.sv]
// Machine control model driving enable and clear-fault pins
`timescale 1ns/1ps
`default_nettype none
module cfs_machine_ctrl (
    // Clock
    input wire logic clk,
    // Control pins
    output logic enable_pin,
    output logic clear_pin
);
    initial begin
        enable_pin = 1'b0;
        clear_pin = 1'b0;
    end
    task automatic set_enable(input logic v);
        @(posedge clk);
        enable_pin <= v;
    endtask
    // Pins are synchronised inside, so a request lasts three cycles
    task automatic clear_fault(input logic via_enable);
        @(posedge clk);
        if (via_enable)
            enable_pin <= 1'b0;
        else
            clear_pin <= 1'b1;
        repeat (3) @(posedge clk);
        enable_pin <= 1'b1;
        clear_pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [dv/cfs_fault_supervisor_test.sv]
// Self-checking bench for the cutter fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "cfs_map.vh"
module cfs_fault_supervisor_test;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, selftest_fail = 1'b0, sync_zone = 1'b0;
    logic cycle_start = 1'b0, at_home = 1'b1, cut_len_short = 1'b0;
    logic cut_active = 1'b0;
    logic homing_active = 1'b0, cut_pulse = 1'b0, rev_mark = 1'b0;
    logic proc_cycle_tick = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [10:0] src = 11'h000;
    wire [31:0] prdata;
    wire pready, pslverr, error_out, roll_hold, cut_refuse, irq;
    wire en_pin, clr_pin;
    int n_errors = 0;
    int total_checks = 0;
    logic [31:0] exp_q[$];
    logic [7:0] codes [6] = '{`CFS_CODE_PWR_LOW, `CFS_CODE_MARK_OVF,
        `CFS_CODE_PROF_OVF, `CFS_CODE_FW, `CFS_CODE_TEMP, `CFS_CODE_BUS};

    always #5 pclk = ~pclk;

    cfs_machine_ctrl mc (.clk(pclk), .enable_pin(en_pin), .clear_pin(clr_pin));
    cfs_fault_supervisor dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ctrl_enable_pin(en_pin),
        .clear_fault_pin(clr_pin), .selftest_fail(selftest_fail),
        .supply_low(src[0]), .homing_active(homing_active),
        .sync_zone(sync_zone), .cut_pulse(cut_pulse),
        .rev_mark(rev_mark), .cycle_start(cycle_start),
        .at_home(at_home), .mark_buf_ovf(src[1]), .profile_ovf(src[2]),
        .cut_len_short(cut_len_short), .seq_bad_state(src[3]),
        .proc_cycle_tick(proc_cycle_tick), .rail_fault(src[10:6]),
        .over_temp(src[4]), .fieldbus_fail(src[5]),
        .cut_active(cut_active), .error_out(error_out),
        .roll_hold(roll_hold), .cut_refuse(cut_refuse), .irq(irq));

    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            if (++n > 50) begin
                n_errors++;
                end_of_test;
            end
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_err(input logic v, input int lim);
        int n = 0;
        @(negedge pclk);
        while (error_out !== v) begin
            if (++n > lim) begin
                n_errors++;
                end_of_test;
            end
            @(negedge pclk);
        end
    endtask
    task automatic settle(input logic via_enable);
        mc.clear_fault(via_enable);
        repeat (6) @(negedge pclk);
        check("error_out", error_out, 0);
        rd(`CFS_REG_CODE, `CFS_CODE_NONE);
    endtask

    // Read data is judged against the oldest queued expectation
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            check("prdata", prdata, exp_q.pop_front());
    end

    initial begin
        logic [31:0] e;
        void'($urandom(60));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`CFS_REG_CODE, `CFS_CODE_NONE);
        rd(`CFS_REG_CTRL, 32'h0);
        rd(`CFS_REG_IRQ_MASK, 32'h0);
        rd(`CFS_REG_WDOG, 32'h0);
        rd(12'h018, 32'h0);
        apb(1'b1, `CFS_REG_CTRL, 32'h1);
        apb(1'b1, 12'h018, $urandom);
        rd(`CFS_REG_CTRL, 32'h1);
        apb(1'b1, `CFS_REG_IRQ_MASK, 32'h1);
        mc.set_enable(1'b1);
        for (int i = 0; i < 11; i++) begin
            e = i > 5 ? `CFS_CODE_SUPPLY0 + i - 6 : codes[i];
            @(posedge pclk);
            cut_active <= i == 1;
            src[i] <= 1'b1;
            wait_err(1'b1, 20);
            check("irq", irq, 1);
            if (i == 1) begin
                check("early_hold", roll_hold, 0);
                @(posedge pclk);
                cut_active <= 1'b0;
            end
            repeat (6) @(negedge pclk);
            check("roll_hold", roll_hold, 1);
            rd(`CFS_REG_CODE, e);
            repeat ($urandom % 4) @(posedge pclk);
            if (i > 0) begin
                mc.clear_fault(i[0]);
                repeat (6) @(negedge pclk);
                check("refault", error_out, 1);
            end
            @(posedge pclk);
            src[i] <= 1'b0;
            if (i == 0) begin
                wait_err(1'b0, 20);
                rd(`CFS_REG_CODE, `CFS_CODE_NONE);
            end else
                settle(i[0]);
            apb(1'b1, `CFS_REG_IRQ_STAT, 32'h7);
            @(negedge pclk);
            check("irq_clear", irq, 0);
        end
        @(posedge pclk);
        src[4] <= 1'b1;
        wait_err(1'b1, 20);
        @(posedge pclk);
        src[1] <= 1'b1;
        repeat (6) @(negedge pclk);
        rd(`CFS_REG_CODE, `CFS_CODE_TEMP);
        @(posedge pclk);
        src <= 11'h000;
        settle(1'b0);
        @(posedge pclk);
        sync_zone <= 1'b1;
        repeat (2) @(posedge pclk);
        cut_pulse <= 1'b1;
        repeat (3) @(posedge pclk);
        sync_zone <= 1'b0;
        cut_pulse <= 1'b0;
        repeat (6) @(negedge pclk);
        check("zone_cut", error_out, 0);
        @(posedge pclk);
        sync_zone <= 1'b1;
        repeat (5) @(posedge pclk);
        sync_zone <= 1'b0;
        wait_err(1'b1, 20);
        rd(`CFS_REG_CODE, `CFS_CODE_NO_CUT);
        settle(1'b1);
        @(posedge pclk);
        homing_active <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            repeat (4) @(negedge pclk);
            if (k == 2)
                check("homing_cut", error_out, 0);
            @(posedge pclk);
            rev_mark <= 1'b1;
            cut_pulse <= k == 0;
            repeat (4) @(posedge pclk);
            rev_mark <= 1'b0;
            cut_pulse <= 1'b0;
        end
        wait_err(1'b1, 20);
        rd(`CFS_REG_CODE, `CFS_CODE_NO_CUT);
        @(posedge pclk);
        homing_active <= 1'b0;
        settle(1'b0);
        @(posedge pclk);
        cut_len_short <= 1'b1;
        cycle_start <= 1'b1;
        wait_err(1'b1, 20);
        check("cut_refuse", cut_refuse, 1);
        rd(`CFS_REG_CODE, `CFS_CODE_SHORT);
        @(posedge pclk);
        cut_len_short <= 1'b0;
        cycle_start <= 1'b0;
        settle(1'b0);
        @(posedge pclk);
        at_home <= 1'b0;
        cycle_start <= 1'b1;
        repeat (6) @(negedge pclk);
        rd(`CFS_REG_CODE, `CFS_CODE_NO_HOME);
        check("report_hold", roll_hold, 0);
        @(posedge pclk);
        cycle_start <= 1'b0;
        at_home <= 1'b1;
        settle(1'b0);
        for (int k = 0; k < 5; k++) begin
            @(posedge pclk);
            proc_cycle_tick <= 1'b1;
            @(posedge pclk);
            proc_cycle_tick <= 1'b0;
            if (k == 0)
                apb(1'b1, `CFS_REG_WDOG, 32'h1);
            repeat (400) @(negedge pclk);
            check("wdog_kicked", error_out, 0);
        end
        wait_err(1'b1, 1200);
        rd(`CFS_REG_CODE, `CFS_CODE_WDOG);
        apb(1'b1, `CFS_REG_WDOG, 32'h0);
        settle(1'b0);
        @(posedge pclk);
        selftest_fail <= 1'b1;
        wait_err(1'b1, 20);
        repeat (6) @(negedge pclk);
        check("hw_hold", roll_hold, 0);
        rd(`CFS_REG_CODE, `CFS_CODE_HW);
        @(posedge pclk);
        selftest_fail <= 1'b0;
        mc.clear_fault(1'b0);
        repeat (8) @(negedge pclk);
        check("hw_sticky", error_out, 1);
        end_of_test;
    end
endmodule
`default_nettype wire
